// [src/dds_defs.vh]
// Constants for the download destination select register block.
// Assumes an APB master on pclk and a copy engine that honours the start and abort signals.
// Overview of operation
// RULE1 - Eight-bit read/write register: bit 7 range error, bits 6..0 destination code, reset zero.
// RULE2 - Setting start-copy triggers a range check of the destination code against 0x00..0x03.
// RULE3 - Codes 0x04 and above set the range error flag and abort the copy.
// RULE4 - Software clears the error flag and loads a legal code before starting.
// RULE5 - Code 0x00 copies to 0xFFE080; code 0x01 copies to 0xFF0800.
// RULE6 - Code 0x02 copies to 0xFF1800; code 0x03 copies to 0xFF8800.
// RULE7 - Software writes the destination register before setting start-copy.
// RULE8 - A successful download fills 2 kbytes of RAM from the selected start address.
`ifndef DDS_DEFS_VH
`define DDS_DEFS_VH
`define DDS_OFS_DEST 12'h000
`define DDS_OFS_CTRL 12'h004
`define DDS_OFS_STAT 12'h008
`define DDS_DEST_RESET 8'h00
`define DDS_ERR_BIT 7
`define DDS_CODE_MSB 6
`define DDS_CODE_MAX 7'h03
`define DDS_ADDR_CODE0 24'hFFE080
`define DDS_ADDR_CODE1 24'hFF0800
`define DDS_ADDR_CODE2 24'hFF1800
`define DDS_ADDR_CODE3 24'hFF8800
`define DDS_COPY_BYTES 24'h000800
`define DDS_START_BIT 0
`define DDS_ST_IDLE 2'h0
`define DDS_ST_COPY 2'h1
`define DDS_ST_DONE 2'h2
`define DDS_DEST_MSB 7
`define DDS_SEL_MSB 1
`define DDS_ADDR_RESET 24'h000000
`define DDS_WORD_ZERO 32'h00000000
`define DDS_PAD_DEST 24'h000000
`define DDS_PAD_STAT 30'h00000000
`endif

// [src/dds_download_destination_select.v]
// Download destination select register with range check and copy request sequencing.
// Assumes an APB master on pclk and a copy engine that acknowledges with copy_done.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`include "dds_defs.vh"
module dds_download_destination_select (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire copy_done,
   output reg copy_req,
   output reg [23:0] copy_start_addr,
   output reg [23:0] copy_end_addr,
   output reg copy_abort
);
   localparam ST_IDLE = `DDS_ST_IDLE;
   localparam ST_COPY = `DDS_ST_COPY;
   localparam ST_DONE = `DDS_ST_DONE;

   // Register state and next values.
   reg [7:0] dest_q;
   reg [7:0] dest_d;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg copy_req_q;
   reg copy_req_d;
   reg copy_abort_q;
   reg copy_abort_d;
   reg [23:0] start_addr_q;
   reg [23:0] start_addr_d;
   reg [23:0] end_addr_q;
   reg [23:0] end_addr_d;
   reg [31:0] rdata_q;
   reg [31:0] rdata_d;
   reg rd_ready_q;
   reg rd_ready_d;
   reg [23:0] base;

   // Bus decode.
   wire acc;
   wire wr;
   wire rd;
   wire hit_dest;
   wire hit_ctrl;
   wire hit_stat;
   wire hit_any;
   wire start;
   wire [6:0] code;
   wire in_range;
   wire bad_start;
   wire good_start;

   assign acc = psel & penable;
   assign wr = acc & pwrite & clk_en;
   assign rd = acc & ~pwrite;
   assign hit_dest = (paddr == `DDS_OFS_DEST);
   assign hit_ctrl = (paddr == `DDS_OFS_CTRL);
   assign hit_stat = (paddr == `DDS_OFS_STAT);
   assign hit_any = hit_dest | hit_ctrl | hit_stat;

   // Start is refused while a copy runs or has just ended, so a second start cannot retarget it.
   assign start = wr & hit_ctrl & pwdata[`DDS_START_BIT] & (state_q == ST_IDLE);
   assign code = dest_q[`DDS_CODE_MSB:0];

   // The full seven-bit code is checked, so a large code can never alias a legal region.
   assign in_range = (code <= `DDS_CODE_MAX); // RULE2
   assign bad_start = start & ~in_range; // RULE3
   assign good_start = start & in_range; // RULE2

   // Start address of each legal destination code.
   always @* begin
      case (code[`DDS_SEL_MSB:0])
         2'h0: begin
            base = `DDS_ADDR_CODE0; // RULE5
         end
         2'h1: begin
            base = `DDS_ADDR_CODE1; // RULE5
         end
         2'h2: begin
            base = `DDS_ADDR_CODE2; // RULE6
         end
         default: begin
            base = `DDS_ADDR_CODE3; // RULE6
         end
      endcase
   end

   // Destination register next value.
   always @* begin
      dest_d = dest_q;
      if (wr & hit_dest) begin
         dest_d = pwdata[`DDS_DEST_MSB:0]; // RULE1
      end
      // The hardware set wins over a software write in the same cycle.
      if (bad_start) begin
         dest_d[`DDS_ERR_BIT] = 1'b1; // RULE3
      end
   end

   // Copy sequencing.
   always @* begin
      state_d = state_q;
      copy_req_d = copy_req_q;
      start_addr_d = start_addr_q;
      end_addr_d = end_addr_q;
      case (state_q)
         ST_IDLE: begin
            if (good_start) begin
               copy_req_d = 1'b1; // RULE2
               start_addr_d = base; // RULE5 RULE6
               end_addr_d = base + `DDS_COPY_BYTES; // RULE8
               state_d = ST_COPY;
            end
         end
         ST_COPY: begin
            if (copy_done) begin
               copy_req_d = 1'b0;
               state_d = ST_DONE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // A failing start never raises the request; it pulses the abort and sets the range error flag.
   always @* begin
      copy_abort_d = bad_start; // RULE3
   end

   // Read data is captured a cycle ahead of the ready cycle.
   always @* begin
      rdata_d = rdata_q;
      if (rd) begin
         if (hit_dest) begin
            rdata_d = {`DDS_PAD_DEST, dest_q};
         end else if (hit_stat) begin
            rdata_d = {`DDS_PAD_STAT, state_q};
         end else begin
            rdata_d = `DDS_WORD_ZERO;
         end
      end
   end

   // Reads answer one cycle into the access phase, so every read with clk_en held high takes one wait state.
   always @* begin
      rd_ready_d = rd & ~rd_ready_q;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dest_q <= `DDS_DEST_RESET; // RULE1
      end else if (clk_en) begin
         dest_q <= dest_d;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         copy_req_q <= 1'b0;
         copy_abort_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         copy_req_q <= copy_req_d;
         copy_abort_q <= copy_abort_d;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_addr_q <= `DDS_ADDR_RESET;
         end_addr_q <= `DDS_ADDR_RESET;
      end else if (clk_en) begin
         start_addr_q <= start_addr_d;
         end_addr_q <= end_addr_d;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= `DDS_WORD_ZERO;
      end else if (clk_en) begin
         rdata_q <= rdata_d;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ready_q <= 1'b0;
      end else if (clk_en) begin
         rd_ready_q <= rd_ready_d;
      end
   end

   // Outputs come straight from the flip-flops.
   always @* begin
      copy_req = copy_req_q;
      copy_abort = copy_abort_q;
      copy_start_addr = start_addr_q;
      copy_end_addr = end_addr_q;
   end

   // Ready is held off while the clock enable is low, since no write could land then.
   assign pready = clk_en & acc & (pwrite | rd_ready_q);
   assign prdata = rdata_q;
   assign pslverr = pready & ~hit_any;
endmodule // dds_download_destination_select

// [dv/dds_chk_sva.sv]
// Checker bound to the destination select block.
// Sees only the clock, reset, clock enable and copy side ports of the block.
module dds_chk(input wire pclk, presetn, clk_en, copy_done, copy_req, copy_abort,
   input wire [23:0] copy_start_addr, copy_end_addr);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_go; $rose(copy_req); endsequence
   property p_len; s_go |-> copy_end_addr == copy_start_addr + 24'h000800; endproperty
   a_len: assert property (p_len) else $error("bad length");
   property p_map; copy_req |-> copy_start_addr inside
      {24'hFFE080, 24'hFF0800, 24'hFF1800, 24'hFF8800}; endproperty
   a_map: assert property (p_map) else $error("bad start");
   property p_hold; copy_req && !copy_done |=> copy_req; endproperty
   a_hold: assert property (p_hold) else $error("req lost");
   sequence s_end; copy_req && copy_done && clk_en; endsequence
   property p_drop; s_end |=> !copy_req; endproperty
   a_drop: assert property (p_drop) else $error("req kept");
   property p_pulse; copy_abort && clk_en |=> !copy_abort; endproperty
   a_pulse: assert property (p_pulse) else $error("long abort");
   property p_excl; copy_abort |-> !copy_req; endproperty
   a_excl: assert property (p_excl) else $error("abort with req");
endmodule // dds_chk
bind dds_download_destination_select dds_chk u_chk(.*);

// [dv/tb_top.sv]
// Bench for the destination select block.
// Drives APB and the copy engine pins itself.
module tb_top;
   timeunit 1ns; timeprecision 1ns;
   logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, copy_done = 0;
   logic pready, pslverr, copy_req, copy_abort, e;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [23:0] copy_start_addr, copy_end_addr;
   logic [23:0] a[4] = '{24'hFFE080, 24'hFF0800, 24'hFF1800, 24'hFF8800};
   int fail_count = 0, num_checks = 0, cyc = 0;
   always #25 pclk = ~pclk;
   always @(posedge pclk) if (++cyc == 3000) report_and_stop(1);
   dds_download_destination_select dut(.*);
   // Ready is looked at once the access phase has settled, ahead of the edge that samples it.
   task xf(input w, input [11:0] ad, input [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      #1;
      while (pready !== 1'b1) begin
         @(posedge pclk);
         #1;
      end
      r = prdata;
      e = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task ck(input [31:0] g, input [31:0] x, input string m);
      num_checks++;
      if (g !== x) begin
         fail_count++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   task t_map;
      xf(0, 12'h000, 32'h0);
      ck(r, 32'h0, "dest reset");
      for (int c = 0; c < 4; c++) begin
         xf(1, 12'h000, c);
         xf(1, 12'h004, 32'h1);
         #1 ck(copy_req, 1, "no request");
         ck(copy_start_addr, a[c], "start address");
         ck(copy_end_addr, a[c] + 24'h000800, "end address");
         xf(0, 12'h008, 32'h0);
         ck(r, 32'h1, "status copying");
         ck(copy_req, 1, "request dropped early");
         @(posedge pclk) copy_done <= 1;
         @(posedge pclk) copy_done <= 0;
         #1 ck(copy_req, 0, "request held");
         repeat (2) @(posedge pclk);
      end
      $display("map done");
   endtask
   task t_err;
      xf(1, 12'h000, 32'h4);
      xf(1, 12'h004, 32'h1);
      #1 ck(copy_abort, 1, "no abort");
      ck(copy_req, 0, "copy not stopped");
      xf(0, 12'h000, 32'h0);
      ck(r, 32'h84, "error flag");
      ck(copy_abort, 0, "abort too long");
      xf(1, 12'h000, 32'h7F);
      xf(1, 12'h004, 32'h1);
      #1 ck(copy_abort, 1, "top code accepted");
      xf(1, 12'h000, 32'h2);
      xf(0, 12'h000, 32'h0);
      ck(r, 32'h2, "flag not cleared");
      xf(0, 12'h00C, 32'h0);
      ck(e, 1, "no slave error");
      ck(r, 32'h0, "unmapped read");
      $display("err done");
   endtask
   task t_busy;
      xf(1, 12'h000, 32'h1);
      xf(1, 12'h004, 32'h1);
      xf(1, 12'h000, 32'h3);
      xf(1, 12'h004, 32'h1);
      #1 ck(copy_start_addr, a[1], "start retargeted");
      @(posedge pclk) clk_en <= 0;
      @(posedge pclk) copy_done <= 1;
      repeat (2) @(posedge pclk);
      #1 ck(copy_req, 1, "frozen request dropped");
      @(posedge pclk) clk_en <= 1;
      @(posedge pclk) copy_done <= 0;
      #1 ck(copy_req, 0, "request not dropped");
      @(posedge pclk) presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      #1 ck(copy_start_addr, 0, "reset address");
      xf(0, 12'h000, 32'h0);
      ck(r, 32'h0, "dest not reset");
      $display("busy done");
   endtask
   task report_and_stop(input int f);
      fail_count += f;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      t_map;
      t_err;
      t_busy;
      report_and_stop(0);
   end
endmodule // tb_top
